// >>> logic/mlsa_arbiter.sv
/*
 mlsa_arbiter: limit sensors, software travel limits and stop-level
 arbitration for a motor driver, with a plain register port.
 assumes motion flags, positions and strobes come from logic on
 sys_clk; the eight stop pins are asynchronous and synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module mlsa_arbiter #(
   parameter int POS_W = 32
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // register port
   input wire logic [mlsa_pkg::MLSA_AW-1:0] reg_addr,
   input wire logic [mlsa_pkg::MLSA_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [mlsa_pkg::MLSA_DW-1:0] reg_rdata,
   // asynchronous stop pins
   input wire logic forward_limit_sensor,
   input wire logic reverse_limit_sensor,
   input wire logic quick_halt_input,
   input wire logic deviation_clear_input,
   input wire logic forward_block_input,
   input wire logic reverse_block_input,
   input wire logic stop_input,
   input wire logic comm_power_lost,
   // requests from driver logic
   input wire logic alarm_stop_req,
   input wire logic maint_stop_cmd,
   input wire logic stop_operation,
   input wire logic alarm_reset,
   // motion profile generator
   input wire logic forward_direction,
   input wire logic reverse_direction,
   input wire logic motor_stopped,
   input wire logic [31:0] profile_rate,
   input wire logic signed [POS_W-1:0] demand_pos,
   input wire logic signed [POS_W-1:0] target_pos,
   input wire logic target_valid,
   input wire logic coord_established,
   input wire logic homing_done,
   input wire logic preset_cmd,
   // stop decision
   output logic stop_active,
   output logic [2:0] stop_level,
   output logic [3:0] stop_source,
   output logic stop_immediate,
   output logic [31:0] stop_rate,
   output logic forward_inhibit,
   output logic reverse_inhibit,
   output logic sot_alarm,
   output logic data_error_alarm,
   output logic coord_preset,
   output logic signed [POS_W-1:0] coord_preset_value
);
   import mlsa_pkg::*;

   typedef struct packed {
      mlsa_state_e st;
      logic [31:0] ctrl;
      logic [31:0] upper;
      logic [31:0] lower;
      logic [31:0] offset;
      logic [31:0] wrap_min;
      logic [31:0] wrap_max;
      logic [31:0] qh_rate;
      logic [31:0] stop_rate;
      logic [31:0] alm_rate;
      logic [31:0] rdata;
      logic [2:0] level;
      logic [3:0] src;
      logic imm;
      logic [31:0] rate;
      logic sot_alarm;
      logic data_err;
      logic fwd_inh;
      logic rvs_inh;
      logic preset;
      logic [31:0] preset_val;
   } mlsa_main_s;

   mlsa_main_s r_ff, nxt_r;
   logic [NPIN-1:0] pin_s;
   logic signed [32:0] pos_x, tgt_x, up_eff, lo_eff;
   logic sw_ok, fwd_en, rvs_en;
   logic dem_up, dem_lo, tgt_up, tgt_lo;

   if (POS_W != 32) begin : g_bad_pos
      $error("mlsa_arbiter position width must be 32");
   end

   mlsa_sync #(
      .WIDTH(NPIN)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .pin_in({comm_power_lost, stop_input, reverse_block_input,
               forward_block_input, deviation_clear_input,
               quick_halt_input, reverse_limit_sensor,
               forward_limit_sensor}),
      .sync_out(pin_s)
   );

   always_comb begin
      pos_x = {demand_pos[POS_W-1], demand_pos};
      tgt_x = {target_pos[POS_W-1], target_pos};
      if (r_ff.ctrl[CRIT_BIT]) begin
         up_eff = {r_ff.upper[31], r_ff.upper};
         lo_eff = {r_ff.lower[31], r_ff.lower};
      end else begin
         up_eff = $signed({r_ff.upper[31], r_ff.upper})
                - $signed({r_ff.offset[31], r_ff.offset});
         lo_eff = $signed({r_ff.lower[31], r_ff.lower})
                - $signed({r_ff.offset[31], r_ff.offset});
      end
   end

   always_comb begin
      sw_ok = coord_established
           && ($signed(r_ff.upper) > $signed(r_ff.lower));
      fwd_en = sw_ok && !(r_ff.ctrl[WRAP_EN_BIT]
           && ($signed(r_ff.upper) > $signed(r_ff.wrap_max)));
      rvs_en = sw_ok && !(r_ff.ctrl[WRAP_EN_BIT]
           && ($signed(r_ff.lower) < $signed(r_ff.wrap_min)));
   end

   mlsa_limit_cmp #(.W(33), .UPPER(1'b1)) u_dem_up (
      .pos(pos_x), .lim(up_eff), .enable(fwd_en), .reached(dem_up));
   mlsa_limit_cmp #(.W(33), .UPPER(1'b0)) u_dem_lo (
      .pos(pos_x), .lim(lo_eff), .enable(rvs_en), .reached(dem_lo));
   mlsa_limit_cmp #(.W(33), .UPPER(1'b1)) u_tgt_up (
      .pos(tgt_x), .lim(up_eff), .enable(fwd_en), .reached(tgt_up));
   mlsa_limit_cmp #(.W(33), .UPPER(1'b0)) u_tgt_lo (
      .pos(tgt_x), .lim(lo_eff), .enable(rvs_en), .reached(tgt_lo));

   function automatic logic [32:0] react(input logic [1:0] base,
      input logic [31:0] c, input logic [31:0] prof,
      input logic [31:0] qr, input logic [31:0] sr);
      logic [32:0] res;
      res = {1'b1, RATE_IMM};
      unique case (base)
         RX_IMM: res = {1'b1, RATE_IMM};
         RX_PROFILE: res = {1'b0, prof};
         RX_QHALT: res = c[QH_IMM_BIT] ? {1'b1, RATE_IMM} : {1'b0, qr};
         RX_STOP: res = c[STOP_IMM_BIT] ? {1'b1, RATE_IMM} : {1'b0, sr};
      endcase
      return res;
   endfunction

   function automatic logic [32:0] stronger(input logic [32:0] a,
      input logic [32:0] b);
      logic pick_a;
      pick_a = a[32] || (!b[32] && (a[31:0] >= b[31:0]));
      return pick_a ? a : b;
   endfunction

   logic [32:0] rx_alm, rx_ls, rx_sot, rx_blk, rx_qh, rx_stop;
   logic ls_on, sot_on, any_req, take;
   logic [NSRC-1:0] req;
   logic [2:0] lvl [NSRC];
   logic [32:0] rx [NSRC];
   logic [2:0] best_lvl;
   logic [3:0] best_src;
   logic [32:0] best_rx;

   always_comb begin
      rx_alm = react(r_ff.ctrl[ALM_ACT_LSB +: 2], r_ff.ctrl,
                     r_ff.alm_rate, r_ff.qh_rate, r_ff.stop_rate);
      rx_ls = react(r_ff.ctrl[LS_ACT_LSB +: 2], r_ff.ctrl,
                    profile_rate, r_ff.qh_rate, r_ff.stop_rate);
      rx_sot = react(r_ff.ctrl[SOT_ACT_LSB +: 2], r_ff.ctrl,
                     profile_rate, r_ff.qh_rate, r_ff.stop_rate);
      rx_blk = react(r_ff.ctrl[BLK_ACT_LSB +: 2], r_ff.ctrl,
                     profile_rate, r_ff.qh_rate, r_ff.stop_rate);
      rx_qh = react(RX_QHALT, r_ff.ctrl, profile_rate,
                    r_ff.qh_rate, r_ff.stop_rate);
      rx_stop = react(RX_STOP, r_ff.ctrl, profile_rate,
                      r_ff.qh_rate, r_ff.stop_rate);
      if (r_ff.ctrl[LS_ACT_LSB + ACT_ALARM_BIT]) begin
         rx_ls = stronger(rx_ls, rx_alm);
      end
      if (r_ff.ctrl[SOT_ACT_LSB + ACT_ALARM_BIT]) begin
         rx_sot = stronger(rx_sot, rx_alm);
      end
      ls_on = r_ff.ctrl[LS_ACT_LSB +: 4] != ACT_OFF;
      sot_on = r_ff.ctrl[SOT_ACT_LSB +: 4] != ACT_OFF;
   end

   always_comb begin
      req = '0;
      req[SRC_CLEAR] = pin_s[PIN_CLR];
      req[SRC_ALARM] = alarm_stop_req;
      req[SRC_COMM] = pin_s[PIN_COMM];
      req[SRC_MAINT] = maint_stop_cmd;
      req[SRC_QHALT] = pin_s[PIN_QH];
      req[SRC_FLS] = ls_on && pin_s[PIN_FLS] && forward_direction;
      req[SRC_RLS] = ls_on && pin_s[PIN_RLS] && reverse_direction;
      req[SRC_FBLK] = pin_s[PIN_FBLK] && forward_direction;
      req[SRC_RBLK] = pin_s[PIN_RBLK] && reverse_direction;
      req[SRC_SOT_F] = sot_on && dem_up && forward_direction;
      req[SRC_SOT_R] = sot_on && dem_lo && reverse_direction;
      req[SRC_STOP] = pin_s[PIN_STOP];
      rx[SRC_CLEAR] = {1'b1, RATE_IMM};
      rx[SRC_ALARM] = rx_alm;
      rx[SRC_COMM] = rx_alm;
      rx[SRC_MAINT] = rx_alm;
      rx[SRC_QHALT] = rx_qh;
      rx[SRC_FLS] = rx_ls;
      rx[SRC_RLS] = rx_ls;
      rx[SRC_FBLK] = rx_blk;
      rx[SRC_RBLK] = rx_blk;
      rx[SRC_SOT_F] = rx_sot;
      rx[SRC_SOT_R] = rx_sot;
      rx[SRC_STOP] = rx_stop;
      lvl[SRC_CLEAR] = LVL_IMM;
      lvl[SRC_ALARM] = LVL_ALARM;
      lvl[SRC_COMM] = LVL_ALARM;
      lvl[SRC_MAINT] = LVL_ALARM;
      lvl[SRC_QHALT] = LVL_QHALT;
      lvl[SRC_FLS] = LVL_LIMIT;
      lvl[SRC_RLS] = LVL_LIMIT;
      lvl[SRC_FBLK] = LVL_LIMIT;
      lvl[SRC_RBLK] = LVL_LIMIT;
      lvl[SRC_SOT_F] = LVL_LIMIT;
      lvl[SRC_SOT_R] = LVL_LIMIT;
      lvl[SRC_STOP] = LVL_STOP;
      for (int i = 0; i < NSRC; i++) begin
         if (rx[i][32]) begin
            lvl[i] = LVL_IMM;
         end
      end
   end

   always_comb begin
      best_lvl = LVL_NONE;
      best_src = SRC_NONE_CODE;
      best_rx = '0;
      for (int i = 0; i < NSRC; i++) begin
         if (req[i] && ((lvl[i] < best_lvl) || ((lvl[i] == best_lvl)
             && (rx[i][31:0] > best_rx[31:0])))) begin
            best_lvl = lvl[i];
            best_src = 4'(i);
            best_rx = rx[i];
         end
      end
      // plain stop operation ranks last, at profile rate
      if (stop_operation && (best_lvl == LVL_NONE)) begin
         best_lvl = LVL_OP;
         best_src = 4'(NSRC);
         best_rx = {1'b0, profile_rate};
      end
      any_req = best_lvl != LVL_NONE;
   end

   always_comb begin
      nxt_r = r_ff;
      nxt_r.preset = 1'b0;
      nxt_r.rdata = '0;
      take = any_req && ((r_ff.st == MLSA_RUN)
          || (best_lvl < r_ff.level) || ((best_lvl == r_ff.level)
          && (best_rx[31:0] > r_ff.rate)));
      unique case (r_ff.st)
         MLSA_RUN: begin
            if (take) begin
               nxt_r.st = MLSA_STOPPING;
            end
         end
         MLSA_STOPPING: begin
            // held stop ends once still and nothing asks
            if (motor_stopped && !any_req) begin
               nxt_r.st = MLSA_RUN;
               nxt_r.level = LVL_NONE;
               nxt_r.src = SRC_NONE_CODE;
               nxt_r.imm = 1'b0;
               nxt_r.rate = '0;
            end
         end
      endcase
      if (take) begin
         nxt_r.level = best_lvl;
         nxt_r.src = best_src;
         nxt_r.imm = best_rx[32];
         nxt_r.rate = best_rx[31:0];
      end
      // only the reached side is blocked
      nxt_r.fwd_inh = (ls_on && pin_s[PIN_FLS]) || pin_s[PIN_FBLK]
                   || (sot_on && dem_up);
      nxt_r.rvs_inh = (ls_on && pin_s[PIN_RLS]) || pin_s[PIN_RBLK]
                   || (sot_on && dem_lo);
      // alarm after standstill; set beats clear
      nxt_r.sot_alarm = (r_ff.sot_alarm && !alarm_reset)
         || ((r_ff.st == MLSA_STOPPING) && motor_stopped
         && r_ff.ctrl[SOT_ACT_LSB + ACT_ALARM_BIT] && sot_on
         && ((r_ff.src == 4'(SRC_SOT_F))
          || (r_ff.src == 4'(SRC_SOT_R))));
      nxt_r.data_err = (r_ff.data_err && !alarm_reset)
         || (target_valid && (tgt_up || tgt_lo));
      if (homing_done || preset_cmd) begin
         nxt_r.preset = 1'b1;
         nxt_r.preset_val = r_ff.offset;
      end
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_CTRL: nxt_r.ctrl = {16'h0000, reg_wdata[CTRL_USED-1:0]};
            ADDR_UPPER: nxt_r.upper = reg_wdata;
            ADDR_LOWER: nxt_r.lower = reg_wdata;
            ADDR_OFFSET: nxt_r.offset = reg_wdata;
            ADDR_WRAP_MIN: nxt_r.wrap_min = reg_wdata;
            ADDR_WRAP_MAX: nxt_r.wrap_max = reg_wdata;
            ADDR_QH_RATE: nxt_r.qh_rate = reg_wdata;
            ADDR_STOP_RATE: nxt_r.stop_rate = reg_wdata;
            ADDR_ALM_RATE: nxt_r.alm_rate = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CTRL: nxt_r.rdata = r_ff.ctrl;
            ADDR_UPPER: nxt_r.rdata = r_ff.upper;
            ADDR_LOWER: nxt_r.rdata = r_ff.lower;
            ADDR_OFFSET: nxt_r.rdata = r_ff.offset;
            ADDR_WRAP_MIN: nxt_r.rdata = r_ff.wrap_min;
            ADDR_WRAP_MAX: nxt_r.rdata = r_ff.wrap_max;
            ADDR_QH_RATE: nxt_r.rdata = r_ff.qh_rate;
            ADDR_STOP_RATE: nxt_r.rdata = r_ff.stop_rate;
            ADDR_ALM_RATE: nxt_r.rdata = r_ff.alm_rate;
            ADDR_STATUS: begin
               nxt_r.rdata[ST_LVL_LSB +: 3] = r_ff.level;
               nxt_r.rdata[ST_SRC_LSB +: 4] = r_ff.src;
               nxt_r.rdata[ST_ACTIVE_BIT] = r_ff.st == MLSA_STOPPING;
               nxt_r.rdata[ST_IMM_BIT] = r_ff.imm;
               nxt_r.rdata[ST_SOT_ALM_BIT] = r_ff.sot_alarm;
               nxt_r.rdata[ST_DERR_BIT] = r_ff.data_err;
               nxt_r.rdata[ST_FINH_BIT] = r_ff.fwd_inh;
               nxt_r.rdata[ST_RINH_BIT] = r_ff.rvs_inh;
               nxt_r.rdata[ST_COORD_BIT] = coord_established;
            end
            default: nxt_r.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r_ff <= '0;
         r_ff.st <= MLSA_RUN;
         r_ff.ctrl <= CTRL_RST;
         r_ff.qh_rate <= RATE_RST;
         r_ff.stop_rate <= RATE_RST;
         r_ff.alm_rate <= RATE_RST;
         r_ff.level <= LVL_NONE;
         r_ff.src <= SRC_NONE_CODE;
      end else if (ce) begin
         r_ff <= nxt_r;
      end
   end

   assign reg_rdata = r_ff.rdata;
   assign stop_active = r_ff.st == MLSA_STOPPING;
   assign stop_level = r_ff.level;
   assign stop_source = r_ff.src;
   assign stop_immediate = r_ff.imm;
   assign stop_rate = r_ff.rate;
   assign forward_inhibit = r_ff.fwd_inh;
   assign reverse_inhibit = r_ff.rvs_inh;
   assign sot_alarm = r_ff.sot_alarm;
   assign data_error_alarm = r_ff.data_err;
   assign coord_preset = r_ff.preset;
   assign coord_preset_value = r_ff.preset_val;
endmodule
`default_nettype wire

// >>> logic/mlsa_limit_cmp.sv
/*
 mlsa_limit_cmp: signed compare of a position against one limit.
 assumes both operands are sign-extended by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module mlsa_limit_cmp #(
   parameter int W = 33,
   parameter bit UPPER = 1'b1
) (
   // operands
   input wire logic signed [W-1:0] pos,
   input wire logic signed [W-1:0] lim,
   input wire logic enable,
   // result
   output logic reached
);
   if (W < 2) begin : g_bad_w
      $error("mlsa_limit_cmp width must be at least two");
   end
   // reaching counts, so the limit value itself is outside
   assign reached = enable && (UPPER ? (pos >= lim) : (pos <= lim));
endmodule
`default_nettype wire

// >>> logic/mlsa_pkg.sv
/*
 mlsa_pkg: register map, field positions, reset values, stop levels
 and source codes for the motion limit stop arbiter.
 assumes a 32-bit register port with byte addresses, one word each.
*/
package mlsa_pkg;
   localparam int MLSA_AW = 6;
   localparam int MLSA_DW = 32;
   // register byte addresses
   localparam logic [5:0] ADDR_CTRL = 6'h00;
   localparam logic [5:0] ADDR_UPPER = 6'h04;
   localparam logic [5:0] ADDR_LOWER = 6'h08;
   localparam logic [5:0] ADDR_OFFSET = 6'h0c;
   localparam logic [5:0] ADDR_WRAP_MIN = 6'h10;
   localparam logic [5:0] ADDR_WRAP_MAX = 6'h14;
   localparam logic [5:0] ADDR_QH_RATE = 6'h18;
   localparam logic [5:0] ADDR_STOP_RATE = 6'h1c;
   localparam logic [5:0] ADDR_ALM_RATE = 6'h20;
   localparam logic [5:0] ADDR_STATUS = 6'h24;
   // control word fields
   localparam int LS_ACT_LSB = 0;
   localparam int SOT_ACT_LSB = 4;
   localparam int BLK_ACT_LSB = 8;
   localparam int ALM_ACT_LSB = 10;
   localparam int QH_IMM_BIT = 12;
   localparam int STOP_IMM_BIT = 13;
   localparam int CRIT_BIT = 14;
   localparam int WRAP_EN_BIT = 15;
   localparam int CTRL_USED = 16;
   // reaction codes: bit 2 adds an alarm, 4'hf is off
   localparam logic [3:0] ACT_OFF = 4'hf;
   localparam int ACT_ALARM_BIT = 2;
   localparam logic [3:0] LS_ACT_RST = 4'h4;
   localparam logic [3:0] SOT_ACT_RST = 4'h6;
   localparam logic [1:0] BLK_ACT_RST = 2'h1;
   localparam logic [1:0] ALM_ACT_RST = 2'h1;
   localparam logic [31:0] CTRL_RST = 32'h0000_0564;
   localparam logic [1:0] RX_IMM = 2'h0;
   localparam logic [1:0] RX_PROFILE = 2'h1;
   localparam logic [1:0] RX_QHALT = 2'h2;
   localparam logic [1:0] RX_STOP = 2'h3;
   localparam logic [31:0] RATE_RST = 32'h0000_03e8;
   localparam logic [31:0] RATE_IMM = 32'hffff_ffff;
   // stop levels, 0 strongest
   localparam logic [2:0] LVL_IMM = 3'h0;
   localparam logic [2:0] LVL_ALARM = 3'h1;
   localparam logic [2:0] LVL_QHALT = 3'h2;
   localparam logic [2:0] LVL_LIMIT = 3'h3;
   localparam logic [2:0] LVL_STOP = 3'h4;
   localparam logic [2:0] LVL_OP = 3'h5;
   localparam logic [2:0] LVL_NONE = 3'h7;
   // stop sources, index into the request table
   localparam int NSRC = 12;
   localparam int SRC_CLEAR = 0;
   localparam int SRC_ALARM = 1;
   localparam int SRC_COMM = 2;
   localparam int SRC_MAINT = 3;
   localparam int SRC_QHALT = 4;
   localparam int SRC_FLS = 5;
   localparam int SRC_RLS = 6;
   localparam int SRC_FBLK = 7;
   localparam int SRC_RBLK = 8;
   localparam int SRC_SOT_F = 9;
   localparam int SRC_SOT_R = 10;
   localparam int SRC_STOP = 11;
   localparam logic [3:0] SRC_NONE_CODE = 4'hf;
   // status word fields
   localparam int ST_LVL_LSB = 0;
   localparam int ST_SRC_LSB = 3;
   localparam int ST_ACTIVE_BIT = 7;
   localparam int ST_IMM_BIT = 8;
   localparam int ST_SOT_ALM_BIT = 9;
   localparam int ST_DERR_BIT = 10;
   localparam int ST_FINH_BIT = 11;
   localparam int ST_RINH_BIT = 12;
   localparam int ST_COORD_BIT = 13;
   // pin synchroniser bit order
   localparam int PIN_FLS = 0;
   localparam int PIN_RLS = 1;
   localparam int PIN_QH = 2;
   localparam int PIN_CLR = 3;
   localparam int PIN_FBLK = 4;
   localparam int PIN_RBLK = 5;
   localparam int PIN_STOP = 6;
   localparam int PIN_COMM = 7;
   localparam int NPIN = 8;
   typedef enum logic {MLSA_RUN, MLSA_STOPPING} mlsa_state_e;
endpackage

// >>> logic/mlsa_sync.sv
/*
 mlsa_sync: two-flop synchroniser for a group of pin levels.
 assumes pins are asynchronous to sys_clk; only stage two is read.
*/
`timescale 1ns/1ps
`default_nettype none
module mlsa_sync #(
   parameter int WIDTH = 8
) (
   // clock and control
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   // pins and synchronised levels
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } mlsa_sync_s;
   mlsa_sync_s r_ff, nxt_r;
   if (WIDTH < 1) begin : g_bad_width
      $error("mlsa_sync width must be at least one");
   end
   always_comb begin
      nxt_r.meta = pin_in;
      nxt_r.stable = r_ff.meta;
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r_ff <= '0;
      end else if (ce) begin
         r_ff <= nxt_r;
      end
   end
   assign sync_out = r_ff.stable;
endmodule
`default_nettype wire

// >>> sim/mlsa_arbiter_tb_top.sv
/* mlsa_arbiter_tb_top: directed tests of the stop arbiter.
   assumes mlsa_partner stands for the profile generator. */
`timescale 1ns/1ps
`default_nettype none
module mlsa_arbiter_tb_top;
   import mlsa_pkg::*;
   logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [5:0] reg_addr = 6'h0;
   logic [31:0] reg_wdata = 32'h0, prate = 32'h32, reg_rdata, stop_rate;
   logic fbk = 0, qh = 0, clr = 0, alm = 0, sop = 0, ars = 0, tv = 0;
   logic coord = 0, hd = 0, stp = 0, fls, rls, fdir, rdir, mst, act, imm;
   logic finh, rinh, sota, derr, cpre;
   logic [1:0] cmd_dir = 2'h0;
   logic [3:0] lag = 4'h3, src;
   logic [2:0] lvl;
   logic signed [31:0] tpos = 32'sd100, dpos, cval;
   int failures = 0, check_count = 0, cyc = 0;
   mlsa_arbiter mlsa_arbiter_i (.sys_clk, .rst, .ce(1'b1), .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .forward_limit_sensor(fls),
      .reverse_limit_sensor(rls), .quick_halt_input(qh),
      .deviation_clear_input(clr), .forward_block_input(fbk),
      .reverse_block_input(1'b0), .stop_input(stp), .comm_power_lost(1'b0),
      .alarm_stop_req(alm), .maint_stop_cmd(1'b0), .stop_operation(sop),
      .alarm_reset(ars), .forward_direction(fdir), .reverse_direction(rdir),
      .motor_stopped(mst), .profile_rate(prate), .demand_pos(dpos),
      .target_pos(tpos), .target_valid(tv), .coord_established(coord),
      .homing_done(hd), .preset_cmd(hd), .stop_active(act),
      .stop_level(lvl), .stop_source(src), .stop_immediate(imm),
      .stop_rate, .forward_inhibit(finh), .reverse_inhibit(rinh),
      .sot_alarm(sota), .data_error_alarm(derr), .coord_preset(cpre),
      .coord_preset_value(cval));
   mlsa_partner mlsa_partner_i (.sys_clk, .cmd_dir, .stop_lag(lag),
      .stop_active(act), .forward_direction(fdir),
      .reverse_direction(rdir), .motor_stopped(mst), .demand_pos(dpos),
      .forward_limit_sensor(fls), .reverse_limit_sensor(rls));
   always #2.5 sys_clk = ~sys_clk;
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // hang guard, runs need about 150 cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(logic [5:0] a, logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      tick(1);
      reg_wr <= 1'b0;
      tick(1);
   endtask
   task automatic rd(logic [5:0] a, logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      tick(1);
      reg_rd <= 1'b0;
      #1 chk("rdata", reg_rdata, exp);
      tick(1);
   endtask
   task automatic see(logic [2:0] l, logic [3:0] s, logic [31:0] r);
      @(negedge sys_clk);
      chk("level", {29'h0, lvl}, {29'h0, l});
      chk("source", {28'h0, src}, {28'h0, s});
      chk("rate", stop_rate, r);
      tick(1);
   endtask
   task automatic wait_act();
      for (int i = 0; i < 200 && act !== 1'b1; i++) @(negedge sys_clk);
   endtask
   initial begin
      tick(12);
      rst <= 1'b0;
      rd(ADDR_CTRL, CTRL_RST);
      rd(ADDR_UPPER, 32'h0);
      rd(ADDR_OFFSET, 32'h0);
      rd(ADDR_STATUS, 32'h7f);
      rd(6'h3c, 32'h0);
      $display("test registers done");
      sop <= 1'b1;
      tick(1);
      see(3'h5, 4'hc, prate);
      stp <= 1'b1;
      tick(3);
      see(3'h4, 4'hb, 32'h3e8);
      alm <= 1'b1;
      tick(1);
      see(3'h1, 4'h1, 32'h3e8);
      qh <= 1'b1;
      tick(3);
      see(3'h1, 4'h1, 32'h3e8);
      clr <= 1'b1;
      tick(3);
      see(3'h0, 4'h0, 32'hffff_ffff);
      {sop, alm, qh, clr, stp} <= 5'h0;
      tick(5);
      see(3'h7, 4'hf, 32'h0);
      $display("test levels done");
      wr(ADDR_UPPER, 32'd30);
      wr(ADDR_LOWER, -32'sd30);
      wr(ADDR_OFFSET, 32'd10);
      wr(ADDR_QH_RATE, 32'd5000);
      tv <= 1'b1;
      tick(1);
      {tv, coord, hd} <= 3'b011;
      @(negedge sys_clk);
      chk("derr", {31'h0, derr}, 32'h0);
      tick(1);
      hd <= 1'b0;
      cmd_dir <= 2'h1;
      @(negedge sys_clk);
      chk("preset", {cval[30:0], cpre}, {31'd10, 1'b1});
      wait_act();
      chk("pos", dpos, 32'd21);
      chk("sota", {31'h0, sota}, 32'h0);
      tick(1);
      see(3'h3, 4'h9, 32'd5000);
      tick(10);
      tv <= 1'b1;
      tick(1);
      tv <= 1'b0;
      @(negedge sys_clk);
      chk("alarms", {30'h0, sota, derr}, 32'h3);
      tick(1);
      ars <= 1'b1;
      wr(ADDR_UPPER, -32'sd30);
      {ars, tv} <= 2'b01;
      tick(1);
      tv <= 1'b0;
      @(negedge sys_clk);
      chk("cleared", {30'h0, sota, derr}, 32'h0);
      tick(1);
      $display("test overtravel done");
      wr(ADDR_CTRL, 32'h661);
      lag <= 4'hf;
      wait_act();
      tick(1);
      see(3'h3, 4'h5, prate);
      fbk <= 1'b1;
      tick(3);
      see(3'h3, 4'h7, 32'd5000);
      {cmd_dir, fbk} <= 3'h0;
      tick(6);
      cmd_dir <= 2'h2;
      tick(3);
      @(negedge sys_clk);
      chk("escape", {29'h0, finh, rinh, rdir}, 32'h5);
      tick(1);
      cmd_dir <= 2'h0;
      wr(ADDR_CTRL, 32'h1661);
      qh <= 1'b1;
      tick(3);
      see(3'h0, 4'h4, 32'hffff_ffff);
      $display("test arbitration done");
      tally_and_finish();
   end
endmodule
bind mlsa_arbiter mlsa_chk mlsa_chk_i (.sys_clk, .rst, .alarm_stop_req,
   .alarm_reset, .motor_stopped, .homing_done, .preset_cmd, .stop_active,
   .stop_level, .stop_source, .stop_immediate, .stop_rate, .sot_alarm,
   .data_error_alarm, .coord_preset);
`default_nettype wire

// >>> sim/mlsa_chk.sv
/* mlsa_chk: port assertions for the stop arbiter.
   assumes it is bound to mlsa_arbiter with ce held high. */
`timescale 1ns/1ps
`default_nettype none
module mlsa_chk (
   // clock and requests
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic alarm_stop_req,
   input wire logic alarm_reset,
   input wire logic motor_stopped,
   input wire logic homing_done,
   input wire logic preset_cmd,
   // stop decision
   input wire logic stop_active,
   input wire logic [2:0] stop_level,
   input wire logic [3:0] stop_source,
   input wire logic stop_immediate,
   input wire logic [31:0] stop_rate,
   input wire logic sot_alarm,
   input wire logic data_error_alarm,
   input wire logic coord_preset
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_alarm_over;
      alarm_stop_req && stop_level > 3'h1;
   endsequence
   sequence s_held;
      stop_active ##1 stop_active;
   endsequence
   a_alarm_level: assert property (s_alarm_over |=> stop_level <= 3'h1)
      else $error("alarm stop above level 1");
   // levels may only get stronger while a stop lasts
   a_no_demote: assert property (s_held |->
      stop_level <= $past(stop_level))
      else $error("stop level weakened");
   a_imm_rate: assert property (stop_immediate |->
      stop_rate == 32'hffff_ffff && stop_level == 3'h0)
      else $error("immediate stop with wrong rate or level");
   a_idle_none: assert property (!stop_active |->
      stop_level == 3'h7 && stop_source == 4'hf)
      else $error("idle but level or source set");
   a_op_level: assert property (stop_active && stop_source == 4'hc |->
      stop_level == 3'h5)
      else $error("stop operation not level 5");
   a_clear_imm: assert property (stop_active && stop_source == 4'h0 |->
      stop_immediate)
      else $error("clear stop not immediate");
   a_sot_late: assert property ($rose(sot_alarm) |->
      $past(motor_stopped))
      else $error("overtravel alarm before motor stopped");
   a_derr_hold: assert property ($fell(data_error_alarm) |->
      $past(alarm_reset))
      else $error("data error dropped without reset");
   a_preset_pulse: assert property (homing_done || preset_cmd |=>
      coord_preset)
      else $error("no coordinate preset pulse");
endmodule
`default_nettype wire

// >>> sim/mlsa_partner.sv
/* mlsa_partner: profile generator and limit sensors.
   assumes cmd_dir and stop_lag come from the bench. */
`timescale 1ns/1ps
`default_nettype none
module mlsa_partner #(
   parameter int LS_POS = 60
) (
   // commands and stop decision
   input wire logic sys_clk,
   input wire logic [1:0] cmd_dir,
   input wire logic [3:0] stop_lag,
   input wire logic stop_active,
   // toward the arbiter
   output logic forward_direction,
   output logic reverse_direction,
   output logic motor_stopped,
   output logic signed [31:0] demand_pos,
   output logic forward_limit_sensor,
   output logic reverse_limit_sensor
);
   logic [3:0] lag_cnt = 4'h0;
   initial demand_pos = 32'sd0;
   // saturate so a long stop cannot wrap back to moving
   always @(posedge sys_clk) begin
      lag_cnt <= !stop_active ? 4'h0 : lag_cnt + {3'h0, lag_cnt != 4'hf};
      if (forward_direction) demand_pos <= demand_pos + 32'sd1;
      if (reverse_direction) demand_pos <= demand_pos - 32'sd1;
   end
   assign motor_stopped = cmd_dir == 2'h0
      || (stop_active && lag_cnt >= stop_lag);
   assign forward_direction = cmd_dir[0] && !motor_stopped;
   assign reverse_direction = cmd_dir[1] && !motor_stopped;
   assign forward_limit_sensor = demand_pos >= LS_POS;
   assign reverse_limit_sensor = demand_pos <= -LS_POS;
endmodule
`default_nettype wire
